//--- logic/nvc_defs.svh
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH
// register indices; byte address is four times the index
`define NVC_IDX_EPCTL 6'h2B
`define NVC_IDX_CONFIG 6'h3F
`define NVC_IDX_EEMAP 6'h2D
`define NVC_IDX_EECTL 6'h3B
`define NVC_IDX_OPTION 6'h39
`define NVC_IDX_PRIO 6'h3C
`define NVC_IDX_PROT 6'h35
`define NVC_IDX_STATUS 6'h3E
// eprom control fields
`define NVC_EP_MLT 7
`define NVC_EP_LAT 5
`define NVC_EP_XCOL 4
`define NVC_EP_XROW 3
`define NVC_EP_VPP 0
// eeprom control fields
`define NVC_EE_BYTE 4
`define NVC_EE_ROW 3
`define NVC_EE_ERASE 2
`define NVC_EE_LAT 1
`define NVC_EE_VPP 0
// configuration fields
`define NVC_CF_RMPLC 2
`define NVC_CF_RMPRS 1
`define NVC_CF_EEEN 0
`define NVC_OPT_PCLK 3
`define NVC_PRIO_BOOT 7
`define NVC_PROT_RESET 5'h1F
// address map
`define NVC_ROM_HI_BASE 16'hA000
`define NVC_ROM_LO_BASE 16'h2000
`define NVC_ROM_LO_LAST 16'h7FFF
`define NVC_EE_LOW 12'hD80
`define NVC_BOOT_BASE 16'hBE00
`define NVC_BOOT_LAST 16'hBFFF
`define NVC_BOOT_ENTRY 16'hBF00
`define NVC_PROT_B1 12'hDA0
`define NVC_PROT_B2 12'hDE0
`define NVC_PROT_B3 12'hE60
`define NVC_PROT_B4 12'hF80
`define NVC_RESP_OKAY 2'h0
`define NVC_RESP_DECERR 2'h3
`endif

//--- logic/nvc_map_prog.sv
// Contract
// - configuration register writable once in normal modes
// - placement bit picks high or low rom window; single-chip mode always uses the high window
// - presence bit set single-chip, cleared test mode
// - eeprom decoded only while enable bit set
// - eeprom map register writable once normally
// - top digit places eeprom at xD80-xFFF
// - boot rom window only special mode, enabled
// - byte eprom programming in every mode
// - multi-byte bit test-only, ignores address bit five
// - latch captures writes, blocks eprom reads
// - latch readable, frozen while voltage bit set
// - extra columns test-only, uses bits 11:5 and 0
// - extra rows test-only, uses bits 5:0
// - voltage bit writable only with latch set
// - utility handshake with host, then resets
// - utility entered by jump to BF00
// - eeprom reads as rom while latch clear
// - eeprom control always accessible, sequence enforced
// - pump clock select: e clock or rc
// - eeprom voltage only after three ordered steps
// - setting latch and voltage together while latch clear clears both
//
// Register access over AXI4-Lite is this design's own decision.
`include "nvc_defs.svh"
module nvc_map_prog
    import nvc_pkg::*;
#(
    parameter logic EEEN_RESET = 1'b1,
    parameter logic RMPLC_EXP_RESET = 1'b1,
    parameter logic RMPRS_EXP_RESET = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic mode_special_i,
    input wire logic mode_test_i,
    input wire logic mode_single_chip_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic cpu_valid_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic rom_sel_o,
    output logic eprom_read_en_o,
    output logic eeprom_sel_o,
    output logic eeprom_read_en_o,
    output logic boot_sel_o,
    output logic boot_entry_o,
    output logic [15:0] eprom_latch_addr_o,
    output logic [7:0] eprom_latch_data_o,
    output logic [11:0] eprom_array_addr_o,
    output logic eprom_bit5_ignore_o,
    output logic eprom_user_off_o,
    output logic eprom_vpp_on_o,
    output logic [15:0] eeprom_latch_addr_o,
    output logic [7:0] eeprom_latch_data_o,
    output logic eeprom_vpp_on_o,
    output logic pump_clk_rc_o
);

// ----------------------------------------
// decode helpers
// ----------------------------------------
    function automatic logic ee_hit(input nvc_addr_t a, input logic [3:0] digit);
        ee_hit = (a[15:12] == digit) && (a[11:0] >= `NVC_EE_LOW);
    endfunction : ee_hit

    function automatic logic [4:0] prot_block(input nvc_addr_t a);
        prot_block = (a[11:0] >= `NVC_PROT_B4) ? 5'h10 :
                     (a[11:0] >= `NVC_PROT_B3) ? 5'h08 :
                     (a[11:0] >= `NVC_PROT_B2) ? 5'h04 :
                     (a[11:0] >= `NVC_PROT_B1) ? 5'h02 : 5'h01;
    endfunction : prot_block

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [5:0] aw_idx_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] rd_byte_w;
    logic rd_map_w, wr_map_w, wr_fire;

    assign s_axi_awready_o = !aw_full_q;
    assign s_axi_wready_o = !w_full_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = rdata_q;
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == `NVC_IDX_EPCTL) || (idx == `NVC_IDX_CONFIG) ||
                 (idx == `NVC_IDX_EEMAP) || (idx == `NVC_IDX_EECTL) ||
                 (idx == `NVC_IDX_OPTION) || (idx == `NVC_IDX_PRIO) ||
                 (idx == `NVC_IDX_PROT) || (idx == `NVC_IDX_STATUS);
    endfunction : mapped

    assign wr_map_w = mapped(aw_idx_q);
    assign rd_map_w = mapped(s_axi_araddr_i[7:2]);

    function automatic logic wr_to(input logic f, input logic [5:0] i, input logic [5:0] t,
                                   input logic s);
        wr_to = f && (i == t) && s;
    endfunction : wr_to

    logic wr_epctl, wr_config, wr_eemap, wr_eectl, wr_option, wr_prio, wr_prot;
    assign wr_epctl = wr_to(wr_fire, aw_idx_q, `NVC_IDX_EPCTL, wstrb0_q);
    assign wr_config = wr_to(wr_fire, aw_idx_q, `NVC_IDX_CONFIG, wstrb0_q);
    assign wr_eemap = wr_to(wr_fire, aw_idx_q, `NVC_IDX_EEMAP, wstrb0_q);
    assign wr_eectl = wr_to(wr_fire, aw_idx_q, `NVC_IDX_EECTL, wstrb0_q);
    assign wr_option = wr_to(wr_fire, aw_idx_q, `NVC_IDX_OPTION, wstrb0_q);
    assign wr_prio = wr_to(wr_fire, aw_idx_q, `NVC_IDX_PRIO, wstrb0_q);
    assign wr_prot = wr_to(wr_fire, aw_idx_q, `NVC_IDX_PROT, wstrb0_q);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            aw_idx_q <= 6'h00;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bresp_q <= `NVC_RESP_OKAY;
            rresp_q <= `NVC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid_i && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr_i[7:2];
            end
            if (s_axi_wvalid_i && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb0_q <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map_w ? `NVC_RESP_OKAY : `NVC_RESP_DECERR;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
            if (s_axi_arvalid_i && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q <= rd_map_w ? `NVC_RESP_OKAY : `NVC_RESP_DECERR;
                rdata_q <= {24'h00_0000, rd_byte_w};
            end else if (rvalid_q && s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

// ----------------------------------------
// configuration and mapping registers
// ----------------------------------------
    logic rmplc_q, rmprs_q, eeen_q, cfg_done_q;
    logic [3:0] ee_digit_q;
    logic eemap_done_q, pclk_q, btrom_q;
    logic [4:0] prot_q;
    logic [2:0] ee_mode_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rmplc_q <= mode_single_chip_i | RMPLC_EXP_RESET;
            rmprs_q <= mode_test_i ? 1'b0 : (mode_single_chip_i | RMPRS_EXP_RESET);
            eeen_q <= EEEN_RESET;
            cfg_done_q <= 1'b0;
            ee_digit_q <= 4'h0;
            eemap_done_q <= 1'b0;
            pclk_q <= 1'b0;
            btrom_q <= mode_special_i & ~mode_test_i;
            prot_q <= `NVC_PROT_RESET;
            ee_mode_q <= 3'h0;
        end else begin
            if (wr_config && (mode_special_i || !cfg_done_q)) begin
                rmplc_q <= wdata_q[`NVC_CF_RMPLC];
                rmprs_q <= wdata_q[`NVC_CF_RMPRS];
                eeen_q <= wdata_q[`NVC_CF_EEEN];
                cfg_done_q <= 1'b1;
            end
            if (wr_eemap && (mode_special_i || !eemap_done_q)) begin
                ee_digit_q <= wdata_q[7:4];
                eemap_done_q <= 1'b1;
            end
            if (wr_option) begin
                pclk_q <= wdata_q[`NVC_OPT_PCLK];
            end
            if (!mode_special_i) begin
                btrom_q <= 1'b0;
            end else if (wr_prio) begin
                btrom_q <= wdata_q[`NVC_PRIO_BOOT];
            end
            if (wr_prot) begin
                prot_q <= wdata_q[4:0];
            end
            if (wr_eectl) begin
                ee_mode_q <= wdata_q[`NVC_EE_BYTE:`NVC_EE_ERASE];
            end
        end
    end

    assign pump_clk_rc_o = pclk_q;

// ----------------------------------------
// address decode
// ----------------------------------------
    logic rom_hi_w, rom_lo_w;
    assign rom_hi_w = (rmplc_q || mode_single_chip_i) && (cpu_addr_i >= `NVC_ROM_HI_BASE);
    assign rom_lo_w = !rmplc_q && !mode_single_chip_i &&
                      (cpu_addr_i >= `NVC_ROM_LO_BASE) && (cpu_addr_i <= `NVC_ROM_LO_LAST);
    assign rom_sel_o = rmprs_q && (rom_hi_w || rom_lo_w);
    assign eeprom_sel_o = eeen_q && ee_hit(cpu_addr_i, ee_digit_q);
    assign boot_sel_o = mode_special_i && btrom_q &&
                        (cpu_addr_i >= `NVC_BOOT_BASE) && (cpu_addr_i <= `NVC_BOOT_LAST);
    // flags the fetch of the resident utility's entry; the utility itself is boot rom code
    assign boot_entry_o = boot_sel_o && cpu_valid_i && !cpu_we_i &&
                          (cpu_addr_i == `NVC_BOOT_ENTRY);

// ----------------------------------------
// eprom programming control
// ----------------------------------------
    logic ep_lat_q, ep_vpp_q, ep_mlt_q, ep_xcol_q, ep_xrow_q;
    logic ep_vpp_next_w, ep_cap_w;
    logic [15:0] ep_addr_q;
    logic [7:0] ep_data_q;

    assign ep_vpp_next_w = ep_lat_q ? wdata_q[`NVC_EP_VPP] : ep_vpp_q;
    assign ep_cap_w = ep_lat_q && !ep_vpp_q && cpu_valid_i && cpu_we_i && rom_sel_o;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ep_lat_q <= 1'b0;
            ep_vpp_q <= 1'b0;
            ep_mlt_q <= 1'b0;
            ep_xcol_q <= 1'b0;
            ep_xrow_q <= 1'b0;
            ep_addr_q <= 16'h0000;
            ep_data_q <= 8'h00;
        end else begin
            if (wr_epctl) begin
                ep_vpp_q <= ep_vpp_next_w;
                // frozen while the voltage stays on; clearing both at once is allowed
                if (!(ep_vpp_q && ep_vpp_next_w)) begin
                    ep_lat_q <= wdata_q[`NVC_EP_LAT];
                end
            end
            if (!mode_test_i) begin
                ep_mlt_q <= 1'b0;
                ep_xcol_q <= 1'b0;
                ep_xrow_q <= 1'b0;
            end else if (wr_epctl) begin
                ep_mlt_q <= wdata_q[`NVC_EP_MLT];
                ep_xcol_q <= wdata_q[`NVC_EP_XCOL];
                ep_xrow_q <= wdata_q[`NVC_EP_XROW];
            end
            if (ep_cap_w) begin
                ep_addr_q <= cpu_addr_i;
                ep_data_q <= cpu_wdata_i;
            end
        end
    end

    assign eprom_read_en_o = rom_sel_o && !ep_lat_q;
    assign eprom_latch_addr_o = ep_addr_q;
    assign eprom_latch_data_o = ep_data_q;
    assign eprom_vpp_on_o = ep_vpp_q;
    assign eprom_bit5_ignore_o = ep_mlt_q;
    assign eprom_user_off_o = ep_xcol_q || ep_xrow_q;
    assign eprom_array_addr_o = ep_xcol_q ? {ep_addr_q[11:5], 4'h0, ep_addr_q[0]} :
                                ep_xrow_q ? {6'h00, ep_addr_q[5:0]} :
                                ep_mlt_q ? {ep_addr_q[11:6], 1'b0, ep_addr_q[4:0]} :
                                ep_addr_q[11:0];

// ----------------------------------------
// eeprom programming sequence
// ----------------------------------------
    nvc_ee_state_e ee_state_q, ee_state_d;
    logic ee_lat_q, ee_vpp_q, ee_lat_d, ee_vpp_d;
    logic ee_cpu_wr_w, ee_load_w, ee_prot_ok_w, ee_cfg_tgt_q;
    logic [15:0] ee_addr_q;
    logic [7:0] ee_data_q;

    // writes into the latch are shut off once the voltage is on
    assign ee_cpu_wr_w = cpu_valid_i && cpu_we_i && eeprom_sel_o;
    assign ee_load_w = (ee_state_q == EE_ARMED) && (ee_cpu_wr_w || wr_config);
    // the configuration target is only unprotected when every block is unprotected
    assign ee_prot_ok_w = ee_cfg_tgt_q ? (prot_q == 5'h00) :
                          ((prot_block(ee_addr_q) & prot_q) == 5'h00);

    always_comb begin
        ee_state_d = ee_state_q;
        ee_lat_d = ee_lat_q;
        ee_vpp_d = ee_vpp_q;
        if (wr_eectl) begin
            case ({wdata_q[`NVC_EE_LAT], wdata_q[`NVC_EE_VPP]})
                2'b11: begin
                    if (!ee_lat_q) begin
                        ee_lat_d = 1'b0;
                        ee_vpp_d = 1'b0;
                        ee_state_d = EE_IDLE;
                    end else if (ee_state_q == EE_LOADED && ee_prot_ok_w) begin
                        ee_vpp_d = 1'b1;
                        ee_state_d = EE_HIGHV;
                    end else begin
                        ee_vpp_d = ee_vpp_q;
                    end
                end
                2'b10: begin
                    ee_lat_d = 1'b1;
                    ee_vpp_d = 1'b0;
                    ee_state_d = EE_ARMED;
                end
                default: begin
                    ee_lat_d = 1'b0;
                    ee_vpp_d = 1'b0;
                    ee_state_d = EE_IDLE;
                end
            endcase
        end else if (ee_load_w) begin
            ee_state_d = EE_LOADED;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ee_state_q <= EE_IDLE;
            ee_lat_q <= 1'b0;
            ee_vpp_q <= 1'b0;
            ee_addr_q <= 16'h0000;
            ee_data_q <= 8'h00;
            ee_cfg_tgt_q <= 1'b0;
        end else begin
            ee_state_q <= ee_state_d;
            ee_lat_q <= ee_lat_d;
            ee_vpp_q <= ee_vpp_d;
            if (ee_lat_q && !ee_vpp_q && !wr_eectl && (ee_cpu_wr_w || wr_config)) begin
                ee_addr_q <= ee_cpu_wr_w ? cpu_addr_i : 16'h0000;
                ee_data_q <= ee_cpu_wr_w ? cpu_wdata_i : wdata_q;
                ee_cfg_tgt_q <= !ee_cpu_wr_w;
            end
        end
    end

    assign eeprom_read_en_o = eeprom_sel_o && !ee_lat_q;
    assign eeprom_latch_addr_o = ee_addr_q;
    assign eeprom_latch_data_o = ee_data_q;
    assign eeprom_vpp_on_o = ee_vpp_q;

// ----------------------------------------
// read data selection
// ----------------------------------------
    logic [5:0] ar_idx_w;
    assign ar_idx_w = s_axi_araddr_i[7:2];
    assign rd_byte_w =
        (ar_idx_w == `NVC_IDX_EPCTL) ? {ep_mlt_q, 1'b0, ep_lat_q, ep_xcol_q, ep_xrow_q,
                                        2'b00, ep_vpp_q} :
        (ar_idx_w == `NVC_IDX_CONFIG) ? {5'h00, rmplc_q, rmprs_q, eeen_q} :
        (ar_idx_w == `NVC_IDX_EEMAP) ? {ee_digit_q, 4'h0} :
        (ar_idx_w == `NVC_IDX_EECTL) ? {3'h0, ee_mode_q, ee_lat_q, ee_vpp_q} :
        (ar_idx_w == `NVC_IDX_OPTION) ? {4'h0, pclk_q, 3'h0} :
        (ar_idx_w == `NVC_IDX_PRIO) ? {btrom_q, 7'h00} :
        (ar_idx_w == `NVC_IDX_PROT) ? {3'h0, prot_q} :
        (ar_idx_w == `NVC_IDX_STATUS) ? {2'b00, ee_state_q, eemap_done_q, cfg_done_q,
                                         ee_cfg_tgt_q, ep_cap_w} : 8'h00;

endmodule : nvc_map_prog

//--- logic/nvc_pkg.sv
package nvc_pkg;
    typedef enum logic [1:0] {EE_IDLE, EE_ARMED, EE_LOADED, EE_HIGHV} nvc_ee_state_e;
    typedef logic [15:0] nvc_addr_t;
endpackage : nvc_pkg

//--- sim/nvc_cpu_model.sv
module nvc_cpu_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic we_o,
    output logic [15:0] addr_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // one bus cycle per access
    // ----------------------------------------
    initial begin
        valid_o = 1'b0;
        we_o = 1'b0;
        addr_o = 16'h0000;
        data_o = 8'h00;
    end
    // returns mid-cycle so the caller can look at the decode while it stands
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        valid_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        data_o <= d;
        @(negedge clk_i);
    endtask : acc
    // idle bus must not look like the last address
    task automatic rel();
        @(posedge clk_i);
        valid_o <= 1'b0;
        we_o <= 1'b0;
        addr_o <= ~addr_o;
        data_o <= ~data_o;
        @(negedge clk_i);
    endtask : rel
endmodule : nvc_cpu_model

//--- sim/nvc_map_prog_sva.sv
module nvc_map_prog_sva (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic mode_special_i,
    input wire logic mode_test_i,
    input wire logic mode_single_chip_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_bvalid_o,
    input wire logic cpu_valid_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic rom_sel_o,
    input wire logic eprom_read_en_o,
    input wire logic eeprom_sel_o,
    input wire logic eeprom_read_en_o,
    input wire logic boot_sel_o,
    input wire logic boot_entry_o,
    input wire logic [15:0] eprom_latch_addr_o,
    input wire logic [7:0] eprom_latch_data_o,
    input wire logic [11:0] eprom_array_addr_o,
    input wire logic eprom_bit5_ignore_o,
    input wire logic eprom_user_off_o,
    input wire logic eprom_vpp_on_o,
    input wire logic eeprom_vpp_on_o,
    input wire logic pump_clk_rc_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    a_latch_capture: assert property (
        cpu_valid_i && cpu_we_i && rom_sel_o && !eprom_read_en_o && !eprom_vpp_on_o
        |=> eprom_latch_addr_o == $past(cpu_addr_i) && eprom_latch_data_o == $past(cpu_wdata_i))
        else $error("eprom write not captured");
    a_ee_read_rom: assert property (
        eeprom_read_en_o |-> eeprom_sel_o && !eeprom_vpp_on_o) else $error("eeprom read enable");
    a_ee_window: assert property (
        eeprom_sel_o |-> cpu_addr_i[11:0] >= 12'hD80) else $error("eeprom outside window");
    a_boot_window: assert property (
        boot_sel_o |-> mode_special_i && cpu_addr_i[15:9] == 7'h5F) else $error("boot window");
    a_boot_entry: assert property (
        boot_entry_o |-> boot_sel_o && cpu_addr_i == 16'hBF00) else $error("boot entry");
    a_rom_window: assert property (
        rom_sel_o |-> cpu_addr_i >= 16'hA000
        || (!mode_single_chip_i && cpu_addr_i inside {[16'h2000:16'h7FFF]}))
        else $error("rom outside window");
    a_test_only: assert property (
        eprom_user_off_o || eprom_bit5_ignore_o |-> mode_test_i) else $error("test bit in use");
    a_bit5_forced: assert property (
        eprom_bit5_ignore_o && !eprom_user_off_o |-> eprom_array_addr_o[5] == 1'b0
        && eprom_array_addr_o[11:6] == eprom_latch_addr_o[11:6]) else $error("bit five kept");
    a_vpp_latch: assert property (
        eprom_vpp_on_o |-> !eprom_read_en_o) else $error("eprom voltage without latch");
    a_ee_vpp_write: assert property (
        $rose(eeprom_vpp_on_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("eeprom voltage without control write");
    a_pump_write: assert property (
        $changed(pump_clk_rc_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("pump clock changed without write");
    a_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read not answered");
endmodule : nvc_map_prog_sva

bind nvc_map_prog nvc_map_prog_sva u_sva (.*);

//--- sim/nvc_map_prog_tb.sv
module nvc_map_prog_tb
    import nvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_EPC = 8'hAC, A_CFG = 8'hFC, A_MAP = 8'hB4, A_PPC = 8'hEC;
    localparam logic [7:0] A_OPT = 8'hE4, A_PRI = 8'hF0, A_PRT = 8'hD4;
    logic sys_clk_i = 1'b0, srst_i = 1'b1;
    logic mode_special_i = 1'b0, mode_test_i = 1'b0, mode_single_chip_i = 1'b1;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdv;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic cpu_valid_i, cpu_we_i, rom_sel_o, eprom_read_en_o, eeprom_sel_o, eeprom_read_en_o;
    logic [15:0] cpu_addr_i, eprom_latch_addr_o, eeprom_latch_addr_o;
    logic [7:0] cpu_wdata_i, eprom_latch_data_o, eeprom_latch_data_o;
    logic [11:0] eprom_array_addr_o;
    logic boot_sel_o, boot_entry_o, eprom_bit5_ignore_o, eprom_user_off_o;
    logic eprom_vpp_on_o, eeprom_vpp_on_o, pump_clk_rc_o;
    int failures = 0, compares = 0;

    always #25 sys_clk_i = ~sys_clk_i;

    nvc_map_prog u_dut (.*);
    nvc_cpu_model u_cpu (
        .clk_i(sys_clk_i),
        .valid_o(cpu_valid_i),
        .we_o(cpu_we_i),
        .addr_o(cpu_addr_i),
        .data_o(cpu_wdata_i)
    );
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // handshakes are judged at the falling edge, where the ready lines have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta = 1'b0, tw = 1'b0, tr = 1'b0;
        @(posedge sys_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!tr) begin
            @(negedge sys_clk_i);
            ta = s_axi_awvalid_i && s_axi_awready_o;
            tw = s_axi_wvalid_i && s_axi_wready_o;
            tr = s_axi_bvalid_o;
            rsp = s_axi_bresp_o;
            @(posedge sys_clk_i);
            if (ta) s_axi_awvalid_i <= 1'b0;
            if (tw) s_axi_wvalid_i <= 1'b0;
        end
        s_axi_bready_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta = 1'b0, tr = 1'b0;
        @(posedge sys_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (!tr) begin
            @(negedge sys_clk_i);
            ta = s_axi_arvalid_i && s_axi_arready_o;
            tr = s_axi_rvalid_o;
            rdv = s_axi_rdata_o;
            rsp = s_axi_rresp_o;
            @(posedge sys_clk_i);
            if (ta) s_axi_arvalid_i <= 1'b0;
        end
        s_axi_rready_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk("readback", rdv, {24'h0, e});
    endtask : rdc
    task automatic pr(input logic [15:0] a);
        u_cpu.acc(1'b0, a, 8'h00);
    endtask : pr
    task automatic cw(input logic [15:0] a, input logic [7:0] d);
        u_cpu.acc(1'b1, a, d);
        u_cpu.rel();
    endtask : cw
    // mode pins are only changed on the edge that asserts reset
    task automatic rst(input logic sp, input logic te, input logic sc);
        @(posedge sys_clk_i);
        mode_special_i <= sp;
        mode_test_i <= te;
        mode_single_chip_i <= sc;
        srst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        srst_i <= 1'b0;
    endtask : rst
    task automatic test_done();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        failures++;
        test_done();
    end
    initial begin
        rst(1'b0, 1'b0, 1'b1);
        rdc(A_CFG, 8'h07);
        pr(16'hA000);
        chk("rom_read", {rom_sel_o, eprom_read_en_o}, 2'h3);
        pr(16'h2000);
        chk("rom_sel", rom_sel_o, 1'b0);
        pr(16'h0D80);
        chk("ee_read", {eeprom_sel_o, eeprom_read_en_o}, 2'h3);
        pr(16'h0D7F);
        chk("ee_sel", eeprom_sel_o, 1'b0);
        pr(16'hBF00);
        chk("boot", {boot_sel_o, boot_entry_o}, 2'h0);
        wr(A_MAP, 8'h30);
        wr(A_MAP, 8'h50);
        rdc(A_MAP, 8'h30);
        wr(A_EPC, 8'h20);
        rdc(A_EPC, 8'h20);
        cw(16'hA123, 8'h5A);
        chk("ep_latch", {eprom_latch_addr_o, eprom_latch_data_o}, 24'hA1235A);
        pr(16'hA000);
        chk("rom_read", {rom_sel_o, eprom_read_en_o}, 2'h2);
        wr(A_EPC, 8'h21);
        chk("ep_vpp", eprom_vpp_on_o, 1'b1);
        wr(A_EPC, 8'h01);
        rdc(A_EPC, 8'h21);
        wr(A_EPC, 8'h00);
        chk("ep_vpp", eprom_vpp_on_o, 1'b0);
        wr(A_EPC, 8'h01);
        rdc(A_EPC, 8'h00);
        wr(A_EPC, 8'hB8);
        rdc(A_EPC, 8'h20);
        chk("ep_test", {eprom_bit5_ignore_o, eprom_user_off_o}, 2'h0);
        wr(A_EPC, 8'h00);
        wr(A_PRT, 8'h00);
        wr(A_PPC, 8'h03);
        rdc(A_PPC, 8'h00);
        wr(A_PPC, 8'h02);
        cw(16'h3D90, 8'h3C);
        chk("ee_latch", {eeprom_latch_addr_o, eeprom_latch_data_o}, 24'h3D903C);
        pr(16'h3D90);
        chk("ee_read", {eeprom_sel_o, eeprom_read_en_o}, 2'h2);
        wr(A_PPC, 8'h03);
        chk("ee_vpp", eeprom_vpp_on_o, 1'b1);
        wr(A_PPC, 8'h00);
        wr(A_PPC, 8'h02);
        wr(A_PPC, 8'h03);
        rdc(A_PPC, 8'h02);
        chk("ee_vpp", eeprom_vpp_on_o, 1'b0);
        wr(A_PPC, 8'h00);
        wr(A_OPT, 8'h08);
        chk("pump", pump_clk_rc_o, 1'b1);
        wr(A_OPT, 8'h00);
        wr(A_CFG, 8'h04);
        wr(A_CFG, 8'h07);
        rdc(A_CFG, 8'h04);
        pr(16'hA000);
        chk("rom_sel", rom_sel_o, 1'b0);
        pr(16'h3D80);
        chk("ee_sel", eeprom_sel_o, 1'b0);
        wr(8'h00, 8'h55);
        chk("bresp", rsp, 2'h3);
        rd(8'h00);
        chk("rresp", rsp, 2'h3);
        rst(1'b1, 1'b1, 1'b0);
        rdc(A_CFG, 8'h05);
        wr(A_CFG, 8'h07);
        wr(A_CFG, 8'h03);
        rdc(A_CFG, 8'h03);
        pr(16'h2000);
        chk("rom_sel", rom_sel_o, 1'b1);
        wr(A_MAP, 8'h10);
        wr(A_MAP, 8'h20);
        rdc(A_MAP, 8'h20);
        wr(A_PRI, 8'h80);
        pr(16'hBF00);
        chk("boot", {boot_sel_o, boot_entry_o}, 2'h3);
        wr(A_EPC, 8'hA0);
        rdc(A_EPC, 8'hA0);
        cw(16'h2025, 8'h77);
        chk("ep_addr", {eprom_bit5_ignore_o, eprom_array_addr_o}, 13'h1005);
        wr(A_EPC, 8'h30);
        chk("ep_addr", {eprom_user_off_o, eprom_array_addr_o}, 13'h1021);
        wr(A_EPC, 8'h28);
        chk("ep_addr", {eprom_user_off_o, eprom_array_addr_o}, 13'h1025);
        wr(A_EPC, 8'h00);
        test_done();
    end
endmodule : nvc_map_prog_tb
